// File: logic/edge_sense.sv
`timescale 1ns/100ps
`default_nettype none
module edge_sense
    import evc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sig,
    input  wire logic [1:0] mode,
    output logic            pulse
);
    // the synchroniser resets low while a pin may idle high, so the first
    // transitions after reset are not real edges; sensing waits until settled
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    logic       prev_r;
    logic       prev_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic       edge_seen;

    // previous sample of the already synchronised level, and settle count
    always_comb begin
        prev_nxt   = sig;
        settle_nxt = (settle_r == SETTLE_DONE) ? settle_r : settle_r + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r   <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            prev_r   <= prev_nxt;
            settle_r <= settle_nxt;
        end
    end

    // the prohibited code senses nothing rather than guessing an edge
    always_comb begin
        unique case (edge_mode_e'(mode))
            EDGE_FALL: edge_seen = prev_r & ~sig;
            EDGE_RISE: edge_seen = ~prev_r & sig;
            EDGE_BOTH: edge_seen = prev_r ^ sig;
            EDGE_BAD:  edge_seen = 1'b0;
        endcase
    end

    assign pulse = edge_seen & (settle_r == SETTLE_DONE);
endmodule
`default_nettype wire

// File: logic/event_gate_top.sv
`timescale 1ns/100ps
`default_nettype none
module event_gate_top
    import evc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [1:0]       hresp,
    output logic [31:0]      hrdata,
    input  wire logic        high_event_input,
    input  wire logic        low_event_input,
    input  wire logic        gate_interrupt_input,
    output logic             high_event_pulse,
    output logic             low_event_pulse,
    output logic             gate_edge_pulse,
    output logic             gating_pwm_output,
    output logic             count_gate_open
);
    logic [ADDR_DEC_W-1:0] wr_addr_r;
    logic [ADDR_DEC_W-1:0] wr_addr_nxt;
    logic                  wr_pend_r;
    logic                  wr_pend_nxt;
    logic [31:0]           hrdata_r;
    logic [31:0]           hrdata_nxt;
    logic                  addr_phase;
    logic [PWM_W-1:0]      period_r;
    logic [PWM_W-1:0]      period_nxt;
    logic [PWM_W-1:0]      data_r;
    logic [PWM_W-1:0]      data_nxt;
    logic [EDGE_W-1:0]     edge_r;
    logic [EDGE_W-1:0]     edge_nxt;
    logic [CLK_SEL_W-1:0]  pclk_r;
    logic [CLK_SEL_W-1:0]  pclk_nxt;
    logic [2:0]            sync1_r;
    logic [2:0]            sync2_r;
    logic                  high_edge;
    logic                  low_edge;
    logic                  gate_edge;
    logic                  pwm_raw;
    logic                  pwm_en;
    logic                  gate_src;
    logic                  hi_pulse_r;
    logic                  lo_pulse_r;
    logic                  gt_pulse_r;
    logic                  pwm_out_r;
    logic                  open_r;
    logic                  hi_pulse_nxt;
    logic                  lo_pulse_nxt;
    logic                  gt_pulse_nxt;
    logic                  open_nxt;
    logic [STATUS_W-1:0]   status;

    // a transfer is taken when selected, ready and non-sequential or sequential
    assign addr_phase = hsel & hready & htrans[1];

    // write address held into the data phase, where hwdata stands
    always_comb begin
        wr_pend_nxt = addr_phase & hwrite;
        wr_addr_nxt = addr_phase ? haddr[ADDR_DEC_W-1:0] : wr_addr_r;
    end

    // register writes; unmapped offsets are ignored with an okay answer
    always_comb begin
        period_nxt = period_r;
        data_nxt   = data_r;
        edge_nxt   = edge_r;
        pclk_nxt   = pclk_r;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                OFS_PERIOD:  period_nxt = hwdata[PWM_W-1:0];
                OFS_DATA:    data_nxt = hwdata[PWM_W-1:0];
                OFS_EDGE:    edge_nxt = hwdata[EDGE_W-1:0];
                OFS_PWM_CLK: pclk_nxt = hwdata[CLK_SEL_W-1:0];
                default:     period_nxt = period_r;
            endcase
        end
    end

    // read data uses next values so a read right after a write sees it
    always_comb begin
        hrdata_nxt = hrdata_r;
        if (addr_phase && !hwrite) begin
            unique case (haddr[ADDR_DEC_W-1:0])
                OFS_PERIOD:  hrdata_nxt = {16'h0000, period_nxt};
                OFS_DATA:    hrdata_nxt = 32'h0000_0000;
                OFS_EDGE:    hrdata_nxt = {24'h00_0000, edge_nxt};
                OFS_PWM_CLK: hrdata_nxt = {29'h0000_0000, pclk_nxt};
                OFS_STATUS:  hrdata_nxt = {27'h000_0000, status};
                default:     hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // bus and register state; zero wait states, so hreadyout stays high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_r <= '0;
            wr_pend_r <= 1'b0;
            hrdata_r  <= 32'h0000_0000;
            period_r  <= PERIOD_RST;
            data_r    <= DATA_RST;
            edge_r    <= EDGE_RST;
            pclk_r    <= PWM_CLK_RST;
        end else begin
            wr_addr_r <= wr_addr_nxt;
            wr_pend_r <= wr_pend_nxt;
            hrdata_r  <= hrdata_nxt;
            period_r  <= period_nxt;
            data_r    <= data_nxt;
            edge_r    <= edge_nxt;
            pclk_r    <= pclk_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // pins are asynchronous: two flops before any logic looks at them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {gate_interrupt_input, low_event_input, high_event_input};
            sync2_r <= sync1_r;
        end
    end

    edge_sense u_high (
        .clk   (hclk),
        .rst_n (hresetn),
        .sig   (sync2_r[0]),
        .mode  (edge_r[HIGH_SEL_LSB+1:HIGH_SEL_LSB]),
        .pulse (high_edge)
    );

    edge_sense u_low (
        .clk   (hclk),
        .rst_n (hresetn),
        .sig   (sync2_r[1]),
        .mode  (edge_r[LOW_SEL_LSB+1:LOW_SEL_LSB]),
        .pulse (low_edge)
    );

    edge_sense u_gate (
        .clk   (hclk),
        .rst_n (hresetn),
        .sig   (sync2_r[2]),
        .mode  (edge_r[GATE_SEL_LSB+1:GATE_SEL_LSB]),
        .pulse (gate_edge)
    );

    assign pwm_en = edge_r[PWM_EN_BIT];

    gating_pwm #(
        .WIDTH (PWM_W)
    ) u_pwm (
        .clk     (hclk),
        .rst_n   (hresetn),
        .enable  (pwm_en),
        .clk_sel (pclk_r),
        .period  (period_r),
        .data    (data_r),
        .pwm_out (pwm_raw)
    );

    // enable picks the pwm over the gate pin
    assign gate_src = pwm_en ? pwm_raw : sync2_r[2];

    // event pulses pass only through an open gate
    always_comb begin
        open_nxt     = gate_src;
        hi_pulse_nxt = high_edge & gate_src;
        lo_pulse_nxt = low_edge & gate_src;
        gt_pulse_nxt = gate_edge & ~pwm_en;
    end

    // outputs registered so the counters see glitch-free pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_pulse_r <= 1'b0;
            lo_pulse_r <= 1'b0;
            gt_pulse_r <= 1'b0;
            pwm_out_r  <= 1'b0;
            open_r     <= 1'b0;
        end else begin
            hi_pulse_r <= hi_pulse_nxt;
            lo_pulse_r <= lo_pulse_nxt;
            gt_pulse_r <= gt_pulse_nxt;
            pwm_out_r  <= pwm_raw;
            open_r     <= open_nxt;
        end
    end

    assign high_event_pulse  = hi_pulse_r;
    assign low_event_pulse   = lo_pulse_r;
    assign gate_edge_pulse   = gt_pulse_r;
    assign gating_pwm_output = pwm_out_r;
    assign count_gate_open   = open_r;

    // live state for software
    always_comb begin
        status              = '0;
        status[ST_HIGH_BIT] = sync2_r[0];
        status[ST_LOW_BIT]  = sync2_r[1];
        status[ST_GATE_BIT] = sync2_r[2];
        status[ST_PWM_BIT]  = pwm_out_r;
        status[ST_OPEN_BIT] = open_r;
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_write_to(logic [7:0] ofs);
        addr_phase && hwrite && haddr[ADDR_DEC_W-1:0] == ofs;
    endsequence

    sequence s_read_of(logic [7:0] ofs);
        addr_phase && !hwrite && haddr[ADDR_DEC_W-1:0] == ofs;
    endsequence

    chk_period_write: assert property (
        s_write_to(OFS_PERIOD) ##1 1'b1 |=> period_r == $past(hwdata[PWM_W-1:0]))
        else $error("period register did not take written word");

    chk_data_write: assert property (
        s_write_to(OFS_DATA) ##1 1'b1 |=> data_r == $past(hwdata[PWM_W-1:0]))
        else $error("data register did not take written word");

    chk_data_reads_zero: assert property (
        s_read_of(OFS_DATA) |=> hrdata == 32'h0000_0000)
        else $error("write-only data register read back nonzero");

    chk_period_readback: assert property (
        s_read_of(OFS_PERIOD) && !wr_pend_r |=> hrdata[PWM_W-1:0] == period_r)
        else $error("period readback mismatch");

    chk_high_fall_edge: assert property (
        edge_r[HIGH_SEL_LSB+1:HIGH_SEL_LSB] == EDGE_FALL && $fell(sync2_r[0]) && gate_src
        |=> high_event_pulse)
        else $error("falling edge on high input missed");

    chk_low_both_edge: assert property (
        edge_r[LOW_SEL_LSB+1:LOW_SEL_LSB] == EDGE_BOTH && $changed(sync2_r[1]) && gate_src
        |=> low_event_pulse)
        else $error("edge on low input missed in both-edge mode");

    chk_barred_code_silent: assert property (
        edge_r[GATE_SEL_LSB+1:GATE_SEL_LSB] == EDGE_BAD
        |=> !gate_edge_pulse)
        else $error("barred edge code produced a gate pulse");

    chk_pwm_halted_low: assert property (
        !pwm_en [*2] |=> !gating_pwm_output)
        else $error("pwm output high while halted");

    chk_gate_pin_route: assert property (
        !pwm_en |=> count_gate_open == $past(sync2_r[2]))
        else $error("gate pin not routed while pwm halted");

    chk_pulse_needs_gate: assert property (
        high_event_pulse || low_event_pulse |-> $past(gate_src))
        else $error("event pulse passed a closed gate");

    chk_pwm_zero_duty: assert property (
        (pwm_en && data_r == DATA_RST) [*3] |-> !gating_pwm_output)
        else $error("pwm high with zero duty data");
endmodule
`default_nettype wire

// File: logic/gating_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module gating_pwm
    import evc_pkg::*;
#(
    parameter int WIDTH = PWM_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 enable,
    input  wire logic [CLK_SEL_W-1:0] clk_sel,
    input  wire logic [WIDTH-1:0]     period,
    input  wire logic [WIDTH-1:0]     data,
    output logic                      pwm_out
);
    logic [PRESCALE_W-1:0] prescale_r;
    logic [PRESCALE_W-1:0] prescale_nxt;
    logic [WIDTH-1:0]      count_r;
    logic [WIDTH-1:0]      count_nxt;
    logic                  out_r;
    logic                  out_nxt;
    logic [PRESCALE_W-1:0] mask;
    logic                  tick;

    // prescale select: upper code bit picks /32 or /64 by its lsb alone
    always_comb begin
        mask = MASK_DIV2;
        if (clk_sel[2]) begin
            mask = clk_sel[0] ? MASK_DIV64 : MASK_DIV32;
        end else begin
            unique case (clk_sel[1:0])
                2'h0: mask = MASK_DIV2;
                2'h1: mask = MASK_DIV4;
                2'h2: mask = MASK_DIV8;
                2'h3: mask = MASK_DIV16;
            endcase
        end
        tick = ((prescale_r & mask) == mask);
    end

    always_comb begin
        prescale_nxt = '0;
        count_nxt    = '0;
        out_nxt      = 1'b0;
        if (enable) begin
            prescale_nxt = prescale_r + 1'b1;
            count_nxt    = count_r;
            if (tick) begin
                count_nxt = (count_r == period) ? '0 : count_r + 1'b1;
            end
            out_nxt = (count_nxt < data);
        end
    end

    // halting clears everything so a restart begins a fresh cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= '0;
            count_r    <= '0;
            out_r      <= 1'b0;
        end else begin
            prescale_r <= prescale_nxt;
            count_r    <= count_nxt;
            out_r      <= out_nxt;
        end
    end

    assign pwm_out = out_r;
endmodule
`default_nettype wire

// File: pkg/evc_pkg.sv
package evc_pkg;
    // register byte offsets within the slave window
    localparam logic [7:0]  OFS_PERIOD      = 8'h00;
    localparam logic [7:0]  OFS_DATA        = 8'h04;
    localparam logic [7:0]  OFS_EDGE        = 8'h08;
    localparam logic [7:0]  OFS_PWM_CLK     = 8'h0C;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam int          ADDR_DEC_W      = 8;
    localparam int          PWM_W           = 16;
    localparam int          EDGE_W          = 8;
    localparam int          CLK_SEL_W       = 3;
    localparam int          PRESCALE_W      = 6;
    localparam int          STATUS_W        = 5;
    // reset values
    localparam logic [15:0] PERIOD_RST      = 16'hFFFF;
    localparam logic [15:0] DATA_RST        = 16'h0000;
    localparam logic [7:0]  EDGE_RST        = 8'h00;
    localparam logic [2:0]  PWM_CLK_RST     = 3'h0;
    // field positions in the edge select register
    localparam int          HIGH_SEL_LSB    = 6;
    localparam int          LOW_SEL_LSB     = 4;
    localparam int          GATE_SEL_LSB    = 2;
    localparam int          PWM_EN_BIT      = 1;
    // field positions in the status register
    localparam int          ST_HIGH_BIT     = 0;
    localparam int          ST_LOW_BIT      = 1;
    localparam int          ST_GATE_BIT     = 2;
    localparam int          ST_PWM_BIT      = 3;
    localparam int          ST_OPEN_BIT     = 4;
    // edge sensing modes
    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_BAD  = 2'h3
    } edge_mode_e;
    // pwm prescale tick masks, divide by 2 up to 64
    localparam logic [5:0]  MASK_DIV2       = 6'h01;
    localparam logic [5:0]  MASK_DIV4       = 6'h03;
    localparam logic [5:0]  MASK_DIV8       = 6'h07;
    localparam logic [5:0]  MASK_DIV16      = 6'h0F;
    localparam logic [5:0]  MASK_DIV32      = 6'h1F;
    localparam logic [5:0]  MASK_DIV64      = 6'h3F;
    localparam logic [1:0]  HRESP_OKAY      = 2'h0;
endpackage

// File: tb/event_counter_pwm_edge_select_test.sv
`timescale 1ns/100ps
`default_nettype none
module event_counter_pwm_edge_select_test;
    import evc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, hresp;
    logic [2:0]  hsize;
    logic        want_high, want_low, want_gate, pwm_prev;
    logic        high_event_input, low_event_input, gate_interrupt_input;
    logic        high_event_pulse, low_event_pulse, gate_edge_pulse;
    logic        gating_pwm_output, count_gate_open;
    int          fails, n_compared, cycles, n_high, n_low, n_gate, n_pwm, n_open, n_rise, div;

    event_gate_top uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .high_event_input(high_event_input), .low_event_input(low_event_input),
        .gate_interrupt_input(gate_interrupt_input), .high_event_pulse(high_event_pulse),
        .low_event_pulse(low_event_pulse), .gate_edge_pulse(gate_edge_pulse),
        .gating_pwm_output(gating_pwm_output), .count_gate_open(count_gate_open)
    );

    event_source src (
        .clk(hclk), .rst_n(hresetn), .want_high(want_high), .want_low(want_low),
        .want_gate(want_gate), .high_event_input(high_event_input),
        .low_event_input(low_event_input), .gate_interrupt_input(gate_interrupt_input)
    );

    // free running clock, 5 ns period
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // pulse counters and hang guard; pulses last one cycle so each edge sample sees one
    always @(posedge hclk) begin
        cycles++;
        if (high_event_pulse === 1'b1) n_high++;
        if (low_event_pulse === 1'b1) n_low++;
        if (gate_edge_pulse === 1'b1) n_gate++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(name, exp, q);
    endtask

    // same mode on all three inputs; events toggle while gate pin is high, then gate toggles
    task automatic edge_run(input logic [1:0] m, input int e);
        wr(OFS_EDGE, {24'h00_0000, m, m, m, 2'b00});
        n_high = 0;
        n_low = 0;
        n_gate = 0;
        want_high <= 1'b1;
        want_low  <= 1'b1;
        repeat (8) @(posedge hclk);
        want_high <= 1'b0;
        want_low  <= 1'b0;
        repeat (8) @(posedge hclk);
        want_gate <= 1'b0;
        repeat (8) @(posedge hclk);
        want_gate <= 1'b1;
        repeat (8) @(posedge hclk);
        check("high pulses", e, n_high);
        check("low pulses", e, n_low);
        check("gate pulses", e, n_gate);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        want_high = 1'b0;
        want_low = 1'b0;
        want_gate = 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("period reset", OFS_PERIOD, 32'h0000_FFFF);
        rd_chk("data reads zero", OFS_DATA, 32'h0000_0000);
        rd_chk("edge reset", OFS_EDGE, 32'h0000_0000);
        rd_chk("unmapped", 8'h14, 32'h0000_0000);
        check("gate open from pin", 32'h0000_0001, {31'h0, count_gate_open});
        rd_chk("status", OFS_STATUS, 32'((1 << ST_GATE_BIT) | (1 << ST_OPEN_BIT)));
        check("okay response", 32'(HRESP_OKAY), 32'(hresp));
        // back to back write then read, upper bits dropped
        wr(OFS_PERIOD, 32'hFFFF_A5C3);
        rd_chk("period readback", OFS_PERIOD, 32'h0000_A5C3);
        wr(OFS_EDGE, 32'h0000_0098);
        rd_chk("edge readback", OFS_EDGE, 32'h0000_0098);
        // every edge code; the barred code senses nothing
        for (int m = 0; m < 4; m++) begin
            edge_run(2'(m), (m == 2) ? 2 : ((m == 3) ? 0 : 1));
        end
        // gate pin low closes the count gate for event pulses
        wr(OFS_EDGE, 32'h0000_00A8);
        want_gate <= 1'b0;
        repeat (8) @(posedge hclk);
        check("gate closed", 32'h0000_0000, {31'h0, count_gate_open});
        n_high = 0;
        want_high <= 1'b1;
        repeat (8) @(posedge hclk);
        want_high <= 1'b0;
        repeat (8) @(posedge hclk);
        check("high pulses gated", 32'h0000_0000, n_high);
        want_gate <= 1'b1;
        // period 3, data 2: half duty, written only while halted
        wr(OFS_PERIOD, 32'h0000_0003);
        wr(OFS_DATA, 32'h0000_0002);
        rd_chk("data write only", OFS_DATA, 32'h0000_0000);
        for (int s = 0; s < 8; s++) begin
            div = (s < 4) ? (2 << s) : ((s % 2) ? 64 : 32);
            wr(OFS_PWM_CLK, 32'(s));
            rd_chk("pwm clock select", OFS_PWM_CLK, 32'(s));
            wr(OFS_EDGE, 32'h0000_00AA);
            repeat (div * 4 + 8) @(posedge hclk);
            n_pwm = 0;
            n_open = 0;
            n_rise = 0;
            n_gate = 0;
            pwm_prev = gating_pwm_output;
            // two whole pwm cycles; gate pin toggles but is deselected
            for (int i = 0; i < 8 * div; i++) begin
                if (i == 2) want_gate <= 1'b0;
                if (i == 10) want_gate <= 1'b1;
                @(posedge hclk);
                if (gating_pwm_output === 1'b1) n_pwm++;
                if (count_gate_open === 1'b1) n_open++;
                if (gating_pwm_output === 1'b1 && pwm_prev === 1'b0) n_rise++;
                pwm_prev = gating_pwm_output;
            end
            check("pwm high cycles", 32'(4 * div), n_pwm);
            check("pwm rises", 32'h0000_0002, n_rise);
            check("gate follows pwm", 32'(4 * div), n_open);
            check("gate pin deselected", 32'h0000_0000, n_gate);
            wr(OFS_EDGE, 32'h0000_00A8);
            repeat (4) @(posedge hclk);
            check("pwm halted", 32'h0000_0000, {31'h0, gating_pwm_output});
        end
        // zero duty data keeps the wave and the count gate low while running
        wr(OFS_DATA, 32'h0000_0000);
        wr(OFS_EDGE, 32'h0000_00AA);
        repeat (16) @(posedge hclk);
        check("pwm zero duty", 32'h0000_0000, {31'h0, gating_pwm_output});
        check("gate shut at zero duty", 32'h0000_0000, {31'h0, count_gate_open});
        wr(OFS_EDGE, 32'h0000_00A8);
        // a second reset in mid-run restores every register
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("period reset again", OFS_PERIOD, 32'h0000_FFFF);
        rd_chk("edge reset again", OFS_EDGE, 32'h0000_0000);
        rd_chk("clock select reset", OFS_PWM_CLK, 32'(PWM_CLK_RST));
        end_sim();
    end
endmodule
`default_nettype wire

// File: tb/event_source.sv
`timescale 1ns/100ps
`default_nettype none
module event_source (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic want_high,
    input  wire logic want_low,
    input  wire logic want_gate,
    output logic      high_event_input,
    output logic      low_event_input,
    output logic      gate_interrupt_input
);
    // pins move one edge after the wish, so every level is held at least one whole cycle;
    // the bench keeps each level for several cycles since shorter pulses may be lost
    // gate pin idles high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_event_input     <= 1'b0;
            low_event_input      <= 1'b0;
            gate_interrupt_input <= 1'b1;
        end else begin
            high_event_input     <= want_high;
            low_event_input      <= want_low;
            gate_interrupt_input <= want_gate;
        end
    end
endmodule
`default_nettype wire
